// ==== contact_prot_map.svh ====
// Register offsets, field positions, reset values and timing counts for contact protection
`ifndef CONTACT_PROT_MAP_SVH
`define CONTACT_PROT_MAP_SVH

// ==========================================================
// Timebase
`define CLK_HZ 250000000
`define TICK_US 100
`define TICK_CYCLES ((`CLK_HZ / 1000000) * `TICK_US)

// ==========================================================
// Settings units: pickup in ms, trip and drop-out in 10 ms
`define PICKUP_MAX_MS 1000
`define TRIP_MAX_CS 30000
`define DROP_MAX_CS 6000
`define PICKUP_DEF_MS 16'h0005
`define TRIP_DEF_CS 16'h0064
`define DROP_DEF_CS 16'h0014
`define TICKS_PER_MS 10
`define TICKS_PER_CS 100

// ==========================================================
// Register map, byte addresses
`define REG_GLOBAL 8'h00
`define REG_STATUS 8'h04
`define REG_INT_STAT 8'h08
`define REG_INT_MASK 8'h0C
`define REG_CH_BASE 8'h10
`define REG_CH_STRIDE 8'h20
`define CH_CTRL 8'h00
`define CH_PICKUP 8'h04
`define CH_TRIP 8'h08
`define CH_DROP 8'h0C
`define CH_PU_CNT 8'h10
`define CH_TR_CNT 8'h14

// ==========================================================
// Field positions
`define CTRL_EN_BIT 0
`define CTRL_OPM_LSB 4
`define CTRL_BLK_LSB 8
`define GLOBAL_GRP_LSB 0

`endif

// ==== contact_prot_pkg.sv ====
// Types shared by the contact protection block
package contact_prot_pkg;
  typedef struct packed {
    logic enable;
    logic [3:0] opmode;
    logic [2:0] blk_sel;
    logic [15:0] pickup_ms;
    logic [15:0] trip_cs;
    logic [15:0] drop_cs;
  } ch_cfg_t;

  typedef struct packed {
    logic [3:0] pickup;
    logic [3:0] trip;
  } prot_out_t;
endpackage

// ==== contact_prot.sv ====
// External contact protection: oil relay and thermal switch instances with Wishbone registers
// Contract
// R1: An instance whose enable is cleared gives no pickup and no trip.
// R2: Each instance has an on/off operate mode per setting group and the active group selects it.
// R3: Trip follows a programmable delay of 0 to 300 s, default 1 s.
// R4: Pickup asserts only after the input persists for 0 to 1000 ms, default 5 ms.
// R5: Pickup is held for a drop-out delay of 0 to 60 s, default 0.2 s, after the input leaves.
// R6: Pickup is inhibited by a selectable source: none or one of four user variables.
// R7: Oil relay has two instances, pressure switch (major fault) and float switch (slow gas).
// R8: The oil relay contacts drive two dedicated inputs, one per oil instance.
// R9: Thermal switch has two instances, trip temperature first and alarm temperature second.
// R10: The thermal switch drives two dedicated inputs, one per thermal instance.
// R11: Each instance counts every pickup assertion.
// R12: Each instance counts every trip assertion.
// R13: Pressure instance is meant to trip at once, float instance to be handled promptly.
// R14: Trip-temperature instance is meant to trip at once, alarm instance only warns.
// R15: Trip asserts after pickup held for the trip delay and clears when pickup drops.
// R16: All timers count a common tick of at least one millisecond resolution.
//
// Chosen here: the Wishbone register port and the placing of the registers.
`include "contact_prot_map.svh"
`timescale 1ns/100ps
`default_nettype none

module contact_prot
  import contact_prot_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYCLES,
  parameter int NGRP = 4
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Field contacts: 0 pressure, 1 float, 2 trip temp, 3 alarm temp
  input wire logic [3:0] contact_i,
  // User variables for blocking
  input wire logic [3:0] user_var_i,
  // Outputs
  output contact_prot_pkg::prot_out_t prot_o,
  output logic irq_o
);
  import contact_prot_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_QUAL = 2'b01,
    ST_PICK = 2'b10,
    ST_DROP = 2'b11
  } pu_state_t;

  // ==========================================================
  // Input synchronisers
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic [3:0] uv1_r;
  logic [3:0] uv2_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      uv1_r <= 4'h0;
      uv2_r <= 4'h0;
    end
    else
    begin
      sync1_r <= contact_i; // R8 R10
      sync2_r <= sync1_r;
      uv1_r <= user_var_i;
      uv2_r <= uv1_r;
    end
  end

  // ==========================================================
  // Common 100 us tick
  logic [31:0] tdiv_r;
  logic tick_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tdiv_r <= 32'h0;
      tick_r <= 1'b0;
    end
    else if (tdiv_r == 32'(TICK_CYCLES - 1))
    begin
      tdiv_r <= 32'h0;
      tick_r <= 1'b1; // R16
    end
    else
    begin
      tdiv_r <= tdiv_r + 32'h1;
      tick_r <= 1'b0;
    end
  end

  // ==========================================================
  // Registers
  ch_cfg_t cfg_r [4];
  logic [1:0] grp_r;
  logic [7:0] int_stat_r;
  logic [7:0] int_mask_r;
  logic [31:0] pu_cnt_r [4];
  logic [31:0] tr_cnt_r [4];
  logic [3:0] pu_r;
  logic [3:0] tr_r;
  logic [3:0] pu_rise;
  logic [3:0] tr_rise;

  logic wb_req;
  logic wb_wr;
  logic ch_hit;
  logic [1:0] ch_idx;
  logic [7:0] ch_off;
  logic [7:0] rel_adr;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Write lands on the edge where the master sees ack, with its request still held
  assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign rel_adr = wb_adr_i - `REG_CH_BASE;
  assign ch_hit = (wb_adr_i >= `REG_CH_BASE) && (rel_adr < 8'h80);
  assign ch_idx = rel_adr[6:5];
  assign ch_off = {3'b000, rel_adr[4:0]};

  function automatic logic [15:0] wmask16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0])
      r[7:0] = d[7:0];
    if (sel[1])
      r[15:8] = d[15:8];
    return r;
  endfunction

  function automatic logic [15:0] clip16(input logic [15:0] v, input int maxv);
    return (v > 16'(maxv)) ? 16'(maxv) : v;
  endfunction

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_req;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      grp_r <= 2'b00;
      int_mask_r <= 8'h00;
      for (int i = 0; i < 4; i++)
      begin
        cfg_r[i].enable <= 1'b0;
        cfg_r[i].opmode <= 4'hF;
        cfg_r[i].blk_sel <= 3'h0;
        cfg_r[i].pickup_ms <= `PICKUP_DEF_MS;
        cfg_r[i].trip_cs <= `TRIP_DEF_CS;
        cfg_r[i].drop_cs <= `DROP_DEF_CS;
      end
    end
    else if (wb_wr)
    begin
      if (wb_adr_i == `REG_GLOBAL && wb_sel_i[0])
        grp_r <= wb_dat_i[`GLOBAL_GRP_LSB +: 2];
      if (wb_adr_i == `REG_INT_MASK && wb_sel_i[0])
        int_mask_r <= wb_dat_i[7:0];
      if (ch_hit)
      begin
        case (ch_off)
          `CH_CTRL:
          begin
            if (wb_sel_i[0])
            begin
              cfg_r[ch_idx].enable <= wb_dat_i[`CTRL_EN_BIT];
              cfg_r[ch_idx].opmode <= wb_dat_i[`CTRL_OPM_LSB +: 4];
            end
            if (wb_sel_i[1])
              cfg_r[ch_idx].blk_sel <= wb_dat_i[`CTRL_BLK_LSB +: 3];
          end
          `CH_PICKUP:
            cfg_r[ch_idx].pickup_ms <=
              clip16(wmask16(cfg_r[ch_idx].pickup_ms, wb_dat_i, wb_sel_i), `PICKUP_MAX_MS);
          `CH_TRIP:
            cfg_r[ch_idx].trip_cs <=
              clip16(wmask16(cfg_r[ch_idx].trip_cs, wb_dat_i, wb_sel_i), `TRIP_MAX_CS);
          `CH_DROP:
            cfg_r[ch_idx].drop_cs <=
              clip16(wmask16(cfg_r[ch_idx].drop_cs, wb_dat_i, wb_sel_i), `DROP_MAX_CS);
          default:
            ;
        endcase
      end
    end
  end

  // Sticky events: low nibble pickup, high nibble trip; set beats clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      int_stat_r <= 8'h00;
    else if (wb_wr && wb_adr_i == `REG_INT_STAT && wb_sel_i[0])
      int_stat_r <= (int_stat_r & ~wb_dat_i[7:0]) | {tr_rise, pu_rise};
    else
      int_stat_r <= int_stat_r | {tr_rise, pu_rise};
  end

  assign irq_o = |(int_stat_r & int_mask_r);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0;
    else if (wb_req && !wb_we_i)
    begin
      wb_dat_o <= 32'h0;
      if (wb_adr_i == `REG_GLOBAL)
        wb_dat_o <= {30'h0, grp_r};
      else if (wb_adr_i == `REG_STATUS)
        wb_dat_o <= {24'h0, tr_r, pu_r};
      else if (wb_adr_i == `REG_INT_STAT)
        wb_dat_o <= {24'h0, int_stat_r};
      else if (wb_adr_i == `REG_INT_MASK)
        wb_dat_o <= {24'h0, int_mask_r};
      else if (ch_hit)
      begin
        case (ch_off)
          `CH_CTRL: wb_dat_o <= {21'h0, cfg_r[ch_idx].blk_sel,
                                 cfg_r[ch_idx].opmode, 3'h0, cfg_r[ch_idx].enable};
          `CH_PICKUP: wb_dat_o <= {16'h0, cfg_r[ch_idx].pickup_ms};
          `CH_TRIP: wb_dat_o <= {16'h0, cfg_r[ch_idx].trip_cs};
          `CH_DROP: wb_dat_o <= {16'h0, cfg_r[ch_idx].drop_cs};
          `CH_PU_CNT: wb_dat_o <= pu_cnt_r[ch_idx];
          `CH_TR_CNT: wb_dat_o <= tr_cnt_r[ch_idx];
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  // ==========================================================
  // Protection instances (R7 R9: 0 pressure, 1 float, 2 trip temp, 3 alarm temp)
  pu_state_t st_r [4];
  logic [23:0] ptmr_r [4];
  logic [23:0] ttmr_r [4];
  logic [3:0] active;
  logic [3:0] blocked;

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      active[i] = cfg_r[i].enable && cfg_r[i].opmode[grp_r]; // R1 R2
      blocked[i] = (cfg_r[i].blk_sel >= 3'h1) && (cfg_r[i].blk_sel <= 3'h4) &&
                   uv2_r[2'(cfg_r[i].blk_sel - 3'h1)]; // R6
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < 4; i++)
      begin
        st_r[i] <= ST_IDLE;
        ptmr_r[i] <= 24'h0;
      end
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (!active[i] || blocked[i])
        begin
          st_r[i] <= ST_IDLE;
          ptmr_r[i] <= 24'h0;
        end
        else
        begin
          case (st_r[i])
            ST_IDLE:
              if (sync2_r[i])
              begin
                st_r[i] <= ST_QUAL;
                ptmr_r[i] <= 24'h0;
              end
            ST_QUAL:
              if (!sync2_r[i])
                st_r[i] <= ST_IDLE;
              else if (ptmr_r[i] >= 24'(cfg_r[i].pickup_ms) * `TICKS_PER_MS)
                st_r[i] <= ST_PICK; // R4
              else if (tick_r)
                ptmr_r[i] <= ptmr_r[i] + 24'h1;
            ST_PICK:
              if (!sync2_r[i])
              begin
                st_r[i] <= ST_DROP;
                ptmr_r[i] <= 24'h0;
              end
            ST_DROP:
              if (sync2_r[i])
                st_r[i] <= ST_PICK;
              else if (ptmr_r[i] >= 24'(cfg_r[i].drop_cs) * `TICKS_PER_CS)
                st_r[i] <= ST_IDLE; // R5
              else if (tick_r)
                ptmr_r[i] <= ptmr_r[i] + 24'h1;
            default:
              st_r[i] <= ST_IDLE;
          endcase
        end
      end
    end
  end

  // Trip timer runs while pickup stands; R13 R14 set by a zero trip delay
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pu_r <= 4'h0;
      tr_r <= 4'h0;
      for (int i = 0; i < 4; i++)
        ttmr_r[i] <= 24'h0;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        pu_r[i] <= (st_r[i] == ST_PICK) || (st_r[i] == ST_DROP);
        if (!pu_r[i])
        begin
          tr_r[i] <= 1'b0; // R15
          ttmr_r[i] <= 24'h0;
        end
        else if (ttmr_r[i] >= 24'(cfg_r[i].trip_cs) * `TICKS_PER_CS)
          tr_r[i] <= 1'b1; // R3 R15
        else if (tick_r)
          ttmr_r[i] <= ttmr_r[i] + 24'h1;
      end
    end
  end

  // ==========================================================
  // Edge detect and counters
  logic [3:0] pu_d_r;
  logic [3:0] tr_d_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pu_d_r <= 4'h0;
      tr_d_r <= 4'h0;
    end
    else
    begin
      pu_d_r <= pu_r;
      tr_d_r <= tr_r;
    end
  end

  assign pu_rise = pu_r & ~pu_d_r;
  assign tr_rise = tr_r & ~tr_d_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < 4; i++)
      begin
        pu_cnt_r[i] <= 32'h0;
        tr_cnt_r[i] <= 32'h0;
      end
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (pu_rise[i])
          pu_cnt_r[i] <= pu_cnt_r[i] + 32'h1; // R11
        if (tr_rise[i])
          tr_cnt_r[i] <= tr_cnt_r[i] + 32'h1; // R12
      end
    end
  end

  assign prot_o.pickup = pu_r;
  assign prot_o.trip = tr_r;

endmodule // contact_prot

`default_nettype wire

// ==== contact_prot_monitor.sv ====
// Port assertions for contact protection
`timescale 1ns/100ps
`default_nettype none
module contact_prot_monitor
(
  // Bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Contacts and outputs
  input wire logic [3:0] contact_i,
  input wire logic [3:0] user_var_i,
  input wire contact_prot_pkg::prot_out_t prot_o,
  input wire logic irq_o
);
  import contact_prot_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ==========
  // Checks
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked");
  a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_reset_quiet: assert property ($fell(rst_i) |->
    !wb_ack_o && wb_dat_o == 32'h0 && prot_o == '0 && !irq_o)
    else $error("outputs active after reset");
  a_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
    && wb_adr_i == 8'hFC |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_trip_needs_pick: assert property ((prot_o.trip & ~$past(prot_o.pickup)) == 4'h0)
    else $error("trip without pickup");
  // Long enough to cover sync flops and one tick of lateness
  a_pick_filter: assert property ((!contact_i[0])[*8] ##1 (!contact_i[0])[*4]
    |=> !$rose(prot_o.pickup[0]))
    else $error("pickup without contact");
  a_pick_holds: assert property ((contact_i[0] && user_var_i == 4'h0 && !wb_cyc_i)[*6]
    ##0 prot_o.pickup[0] |=> prot_o.pickup[0])
    else $error("pickup dropped with contact closed");
endmodule // contact_prot_monitor
bind contact_prot contact_prot_monitor contact_prot_monitor_inst (.clk_i(clk_i),
  .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .contact_i(contact_i),
  .user_var_i(user_var_i), .prot_o(prot_o), .irq_o(irq_o));
`default_nettype wire

// ==== contact_field.sv ====
// Field contact model for oil relay and thermal switch
`timescale 1ns/100ps
`default_nettype none
module contact_field
(
  // Clock
  input wire logic clk_i,
  // Commanded levels
  input wire logic [3:0] cmd_i,
  // Contacts: pressure, float, trip temp, alarm temp
  output var logic [3:0] contact_o = 4'h0
);
  // ==========
  // Contacts are driven open or closed, never floating
  always @(posedge clk_i)
    contact_o <= cmd_i;
endmodule // contact_field
`default_nettype wire

// ==== external_contact_protection_tb_top.sv ====
// Bench for contact protection against a count model
`timescale 1ns/100ps
`default_nettype none
`include "contact_prot_map.svh"
module external_contact_protection_tb_top;
  import contact_prot_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic [31:0] rd;
  logic wb_ack_o;
  logic irq_o;
  logic [3:0] cmd = 4'h0;
  logic [3:0] contact_i;
  logic [3:0] user_var_i = 4'h0;
  logic [3:0] b;
  logic [7:0] lfsr_r = 8'h3F;
  prot_out_t prot_o;
  int failures = 0;
  int n_tests = 0;
  int pu_cnt[4] = '{default: 0};
  int tr_cnt[4] = '{default: 0};

  // Tick of 4 cycles: 1 ms is 40 cycles, 10 ms is 400
  contact_prot #(.TICK_CYCLES(4)) contact_prot_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_cyc_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .contact_i(contact_i), .user_var_i(user_var_i), .prot_o(prot_o), .irq_o(irq_o));
  contact_field contact_field_inst (.clk_i(clk_i), .cmd_i(cmd), .contact_o(contact_i));

  initial
    forever #2 clk_i = ~clk_i;

  // ==========
  // Tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic pt(input logic [3:0] p, input logic [3:0] t);
    chk("pickup", 32'(p), 32'(prot_o.pickup));
    chk("trip", 32'(t), 32'(prot_o.trip));
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && ++n < 50);
    if (n >= 50)
      chk("wb_ack", 32'h1, 32'(wb_ack_o));
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  function automatic logic [7:0] ca(input int ch, input logic [7:0] off);
    return 8'(`REG_CH_BASE + `REG_CH_STRIDE * ch + off);
  endfunction
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic cnts;
    for (int k = 0; k < 4; k++)
    begin
      rdc("pu_cnt", ca(k, `CH_PU_CNT), 32'(pu_cnt[k]));
      rdc("tr_cnt", ca(k, `CH_TR_CNT), 32'(tr_cnt[k]));
    end
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========
  // Sequence
  initial
  begin
    tk(10);
    rst_i <= 1'b0;
    rdc("ctrl", ca(0, `CH_CTRL), 32'hF0);
    rdc("pu_dly", ca(0, `CH_PICKUP), 32'h5);
    rdc("tr_dly", ca(0, `CH_TRIP), 32'h64);
    rdc("dr_dly", ca(0, `CH_DROP), 32'h14);
    wb(1'b1, ca(3, `CH_TRIP), 32'hFFFF);
    rdc("tr_clip", ca(3, `CH_TRIP), 32'(`TRIP_MAX_CS));
    wb(1'b1, 8'hFC, 32'hFFFFFFFF);
    rdc("unmapped", 8'hFC, 32'h0);
    cmd <= 4'hF;
    tk(100);
    pt(4'h0, 4'h0);
    cmd <= 4'h0;
    for (int ch = 0; ch < 4; ch++)
    begin
      b = 4'(1 << ch);
      wb(1'b1, ca(ch, `CH_CTRL), 32'hF1);
      wb(1'b1, ca(ch, `CH_PICKUP), 32'h1);
      wb(1'b1, ca(ch, `CH_TRIP), 32'(ch % 2));
      wb(1'b1, ca(ch, `CH_DROP), 32'h1);
      lfsr_r = lfsr(lfsr_r);
      cmd[ch] <= 1'b1;
      tk(1 + lfsr_r % 24);
      cmd[ch] <= 1'b0;
      tk(60);
      pt(4'h0, 4'h0);
      cmd[ch] <= 1'b1;
      tk(30);
      pt(4'h0, 4'h0);
      tk(30);
      pu_cnt[ch]++;
      pt(b, (ch % 2) ? 4'h0 : b);
      tk(350);
      pt(b, (ch % 2) ? 4'h0 : b);
      tk(90);
      tr_cnt[ch]++;
      pt(b, b);
      cmd[ch] <= 1'b0;
      tk(370);
      pt(b, b);
      tk(70);
      pt(4'h0, 4'h0);
      cnts();
    end
    rdc("int_stat", `REG_INT_STAT, 32'hFF);
    chk("irq", 32'h0, 32'(irq_o));
    lfsr_r = lfsr(lfsr_r);
    wb(1'b1, `REG_INT_MASK, 32'(lfsr_r));
    rdc("int_mask", `REG_INT_MASK, 32'(lfsr_r));
    chk("irq", 32'(lfsr_r != 8'h00), 32'(irq_o));
    wb(1'b1, `REG_INT_STAT, 32'h0F);
    rdc("int_stat", `REG_INT_STAT, 32'hF0);
    chk("irq", 32'((lfsr_r & 8'hF0) != 8'h00), 32'(irq_o));
    wb(1'b1, `REG_INT_STAT, 32'hF0);
    rdc("int_stat", `REG_INT_STAT, 32'h0);
    chk("irq", 32'h0, 32'(irq_o));
    wb(1'b1, `REG_GLOBAL, 32'h1);
    wb(1'b1, ca(0, `CH_CTRL), 32'hD1);
    cmd[0] <= 1'b1;
    tk(60);
    pt(4'h0, 4'h0);
    wb(1'b1, `REG_GLOBAL, 32'h0);
    tk(60);
    pu_cnt[0]++;
    tr_cnt[0]++;
    pt(4'h1, 4'h1);
    rdc("status", `REG_STATUS, 32'h11);
    cmd[0] <= 1'b0;
    wb(1'b1, ca(0, `CH_CTRL), 32'hF0);
    for (int v = 1; v < 5; v++)
    begin
      wb(1'b1, ca(1, `CH_CTRL), 32'(v << 8) | 32'hF1);
      rdc("ctrl", ca(1, `CH_CTRL), 32'(v << 8) | 32'hF1);
      user_var_i <= 4'(1 << (v - 1));
      cmd[1] <= 1'b1;
      tk(60);
      pt(4'h0, 4'h0);
      user_var_i <= ~user_var_i;
      tk(60);
      pu_cnt[1]++;
      pt(4'h2, 4'h0);
      user_var_i <= ~user_var_i;
      tk(8);
      pt(4'h0, 4'h0);
      cmd[1] <= 1'b0;
    end
    cnts();
    summarize();
  end

  initial
  begin
    tk(40000);
    failures++;
    summarize();
  end
endmodule // external_contact_protection_tb_top
`default_nettype wire
